// ### spm_pkg.sv
`default_nettype none

package spm_pkg;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_DIRECTION = 8'h04;
  localparam logic [7:0] OFS_OUT_VALUE = 8'h08;
  localparam logic [7:0] OFS_IN_VALUE = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int STATUS_PCI_SEL_BIT = 0;
  localparam int STATUS_LOCKED_BIT = 1;
  localparam logic [15:0] RST_ENABLE = 16'h0000;
  localparam logic [15:0] RST_DIRECTION = 16'h0000;
  localparam logic [15:0] RST_OUT_VALUE = 16'h0000;
  localparam int LINE_ONE = 1;
  localparam int LINE_TWO = 2;
  localparam int UPPER_LO = 9;
  localparam int UPPER_HI = 15;

  // ----------------------------------------
  // clock divider counts
  // ----------------------------------------
  localparam logic [1:0] QUARTER_LAST = 2'h3;
  localparam logic [2:0] SIXTH_LAST = 3'h5;
  localparam logic [2:0] SIXTH_HALF = 3'h3;

  // ----------------------------------------
  // widths and types
  // ----------------------------------------
  localparam int GIO_W = 16;
  localparam int SHARED_W = 42;
  localparam int PCI_ONLY_W = 5;

  typedef enum logic [2:0] {
    IDX_ENABLE,
    IDX_DIRECTION,
    IDX_OUT_VALUE,
    IDX_IN_VALUE,
    IDX_STATUS,
    IDX_NONE
  } spm_reg_idx_t;

  typedef struct packed {
    logic [GIO_W-1:0] out;
    logic [GIO_W-1:0] oe_b;
  } spm_gio_drive_t;

  typedef struct packed {
    logic [SHARED_W-1:0] out;
    logic [SHARED_W-1:0] oe_b;
  } spm_shared_drive_t;

  typedef struct packed {
    logic [PCI_ONLY_W-1:0] out;
    logic [PCI_ONLY_W-1:0] oe_b;
  } spm_pci_only_drive_t;

endpackage

`default_nettype wire

// ### spm_pin_mux.sv
`timescale 1ns/1ns
`default_nettype none

module spm_pin_mux (
  input wire logic clk,                                  // core clock
  input wire logic rst_b,                                // async reset, low
  input wire logic [7:0] avs_address,                    // byte address
  input wire logic avs_read,                             // read request
  input wire logic avs_write,                            // write request
  input wire logic [31:0] avs_writedata,                 // write data
  input wire logic [3:0] avs_byteenable,                 // byte lanes
  output logic [31:0] avs_readdata,                      // read data
  output logic avs_waitrequest,                          // stall
  input wire logic pci_enable_strap,                     // PCI strap pin
  input wire logic [15:0] gio_pin_in,                    // general io pin levels
  output spm_pkg::spm_gio_drive_t gio_pin,               // general io pin drive
  input wire spm_pkg::spm_gio_drive_t pci_upper_drive,   // PCI drive of upper lines
  input wire spm_pkg::spm_shared_drive_t host_drive,     // host port drive
  input wire spm_pkg::spm_shared_drive_t pci_drive,      // PCI drive, shared pins
  input wire logic [41:0] shared_pin_in,                 // shared pin levels
  output spm_pkg::spm_shared_drive_t shared_pin,         // shared pin drive
  output logic [41:0] host_port_in,                      // shared levels to host
  output logic [41:0] pci_in,                            // shared levels to PCI
  input wire spm_pkg::spm_pci_only_drive_t pci_only_drive, // PCI-only drive
  output spm_pkg::spm_pci_only_drive_t pci_only_pin,     // PCI-only pin drive
  output logic host_port_grant,                          // host owns shared pins
  output logic pci_grant                                 // PCI owns shared pins
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic spm_pkg::spm_reg_idx_t reg_index(input logic [7:0] a);
    unique case (a)
      spm_pkg::OFS_ENABLE: reg_index = spm_pkg::IDX_ENABLE;
      spm_pkg::OFS_DIRECTION: reg_index = spm_pkg::IDX_DIRECTION;
      spm_pkg::OFS_OUT_VALUE: reg_index = spm_pkg::IDX_OUT_VALUE;
      spm_pkg::OFS_IN_VALUE: reg_index = spm_pkg::IDX_IN_VALUE;
      spm_pkg::OFS_STATUS: reg_index = spm_pkg::IDX_STATUS;
      default: reg_index = spm_pkg::IDX_NONE;
    endcase
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
    merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  typedef enum logic [2:0] {
    ST_FILL_A,
    ST_FILL_B,
    ST_FILL_C,
    ST_SAMPLE,
    ST_LOCKED
  } spm_strap_state_t;

  logic [15:0] gio_enable, next_gio_enable;
  logic [15:0] gio_direction, next_gio_direction;
  logic [15:0] gio_out_value, next_gio_out_value;
  logic [15:0] gio_s1, gio_s2, gio_s3, gio_in_value, next_gio_in_value;
  logic strap_s1, strap_s2, strap_s3;
  spm_strap_state_t strap_state, next_strap_state;
  logic pci_sel, next_pci_sel;
  logic ack, next_ack;
  logic [31:0] readdata, next_readdata;
  logic [1:0] quarter_cnt, next_quarter_cnt;
  logic [2:0] sixth_cnt, next_sixth_cnt;
  logic quarter_clk, next_quarter_clk;
  logic sixth_clk, next_sixth_clk;
  logic wr_accept;
  spm_pkg::spm_reg_idx_t idx;

  // ----------------------------------------
  // bus slave: one wait state per access
  // ----------------------------------------
  assign idx = reg_index(avs_address);
  assign avs_waitrequest = ~ack;
  assign avs_readdata = readdata;
  assign wr_accept = avs_write & ack;

  always_comb begin
    next_ack = (avs_read | avs_write) & ~ack;
    next_readdata = readdata;
    next_gio_enable = gio_enable;
    next_gio_direction = gio_direction;
    next_gio_out_value = gio_out_value;
    if (avs_read & ~ack) begin
      next_readdata = 32'h0000_0000;
      unique case (idx)
        spm_pkg::IDX_ENABLE: next_readdata[15:0] = gio_enable;
        spm_pkg::IDX_DIRECTION: next_readdata[15:0] = gio_direction;
        spm_pkg::IDX_OUT_VALUE: next_readdata[15:0] = gio_out_value;
        spm_pkg::IDX_IN_VALUE: next_readdata[15:0] = gio_in_value;
        spm_pkg::IDX_STATUS: begin
          next_readdata[spm_pkg::STATUS_PCI_SEL_BIT] = pci_sel;
          next_readdata[spm_pkg::STATUS_LOCKED_BIT] = (strap_state == ST_LOCKED);
        end
        spm_pkg::IDX_NONE: next_readdata = 32'h0000_0000;
      endcase
    end
    if (wr_accept) begin
      unique case (idx)
        spm_pkg::IDX_ENABLE:
          next_gio_enable = merge16(gio_enable, avs_writedata, avs_byteenable);
        spm_pkg::IDX_DIRECTION:
          next_gio_direction = merge16(gio_direction, avs_writedata, avs_byteenable);
        spm_pkg::IDX_OUT_VALUE:
          next_gio_out_value = merge16(gio_out_value, avs_writedata, avs_byteenable);
        spm_pkg::IDX_IN_VALUE, spm_pkg::IDX_STATUS, spm_pkg::IDX_NONE: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'b0;
      readdata <= 32'h0000_0000;
      gio_enable <= spm_pkg::RST_ENABLE;
      gio_direction <= spm_pkg::RST_DIRECTION;
      gio_out_value <= spm_pkg::RST_OUT_VALUE;
    end else begin
      ack <= next_ack;
      readdata <= next_readdata;
      gio_enable <= next_gio_enable;
      gio_direction <= next_gio_direction;
      gio_out_value <= next_gio_out_value;
    end
  end

  // ----------------------------------------
  // pin synchronisers and strap capture
  // ----------------------------------------
  always_comb begin
    next_gio_in_value = (gio_s2 & ~(gio_s2 ^ gio_s3)) | (gio_in_value & (gio_s2 ^ gio_s3));
    next_strap_state = strap_state;
    next_pci_sel = pci_sel;
    // flops hold reset zeros until the pin has passed all three
    unique case (strap_state)
      ST_FILL_A: next_strap_state = ST_FILL_B;
      ST_FILL_B: next_strap_state = ST_FILL_C;
      ST_FILL_C: next_strap_state = ST_SAMPLE;
      ST_SAMPLE: begin
        if (strap_s2 == strap_s3) begin
          next_strap_state = ST_LOCKED;
          next_pci_sel = strap_s3;
        end
      end
      ST_LOCKED: next_strap_state = ST_LOCKED;
      default: next_strap_state = ST_FILL_A;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gio_s1 <= 16'h0000;
      gio_s2 <= 16'h0000;
      gio_s3 <= 16'h0000;
      gio_in_value <= 16'h0000;
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      strap_s3 <= 1'b0;
      strap_state <= ST_FILL_A;
      pci_sel <= 1'b0;
    end else begin
      gio_s1 <= gio_pin_in;
      gio_s2 <= gio_s1;
      gio_s3 <= gio_s2;
      gio_in_value <= next_gio_in_value;
      strap_s1 <= pci_enable_strap;
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
      strap_state <= next_strap_state;
      pci_sel <= next_pci_sel;
    end
  end

  // ----------------------------------------
  // clock dividers
  // ----------------------------------------
  always_comb begin
    next_quarter_cnt = (quarter_cnt == spm_pkg::QUARTER_LAST) ? 2'h0 : quarter_cnt + 2'h1;
    next_sixth_cnt = (sixth_cnt == spm_pkg::SIXTH_LAST) ? 3'h0 : sixth_cnt + 3'h1;
    next_quarter_clk = next_quarter_cnt[1];
    next_sixth_clk = (next_sixth_cnt >= spm_pkg::SIXTH_HALF);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      quarter_cnt <= 2'h0;
      sixth_cnt <= 3'h0;
      quarter_clk <= 1'b0;
      sixth_clk <= 1'b0;
    end else begin
      quarter_cnt <= next_quarter_cnt;
      sixth_cnt <= next_sixth_cnt;
      quarter_clk <= next_quarter_clk;
      sixth_clk <= next_sixth_clk;
    end
  end

  // ----------------------------------------
  // general io pin muxing
  // ----------------------------------------
  for (genvar i = 0; i < spm_pkg::GIO_W; i++) begin : g_line
    logic gio_out, gio_oe_b;
    assign gio_out = gio_out_value[i];
    assign gio_oe_b = ~gio_direction[i];
    if (i == spm_pkg::LINE_ONE || i == spm_pkg::LINE_TWO) begin : g_clk
      logic prim;
      assign prim = (i == spm_pkg::LINE_ONE) ? quarter_clk : sixth_clk;
      assign gio_pin.out[i] = gio_enable[i] ? gio_out : prim;
      assign gio_pin.oe_b[i] = gio_enable[i] ? gio_oe_b : 1'b0;
    end else if (i >= spm_pkg::UPPER_LO && i <= spm_pkg::UPPER_HI) begin : g_upper
      assign gio_pin.out[i] = pci_sel ? pci_upper_drive.out[i]
                            : (gio_enable[i] & gio_out);
      assign gio_pin.oe_b[i] = pci_sel ? pci_upper_drive.oe_b[i]
                             : (~gio_enable[i] | gio_oe_b);
    end else begin : g_plain
      assign gio_pin.out[i] = gio_enable[i] & gio_out;
      assign gio_pin.oe_b[i] = ~gio_enable[i] | gio_oe_b;
    end
  end

  // ----------------------------------------
  // host port / PCI shared pins
  // ----------------------------------------
  assign host_port_grant = ~pci_sel;
  assign pci_grant = pci_sel;
  assign shared_pin = pci_sel ? pci_drive : host_drive;
  assign host_port_in = pci_sel ? 42'h000_0000_0000 : shared_pin_in;
  assign pci_in = pci_sel ? shared_pin_in : 42'h000_0000_0000;
  assign pci_only_pin.out = pci_sel ? pci_only_drive.out : 5'h00;
  assign pci_only_pin.oe_b = pci_sel ? pci_only_drive.oe_b : 5'h1F;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_enable_write;
    avs_write & ack & (idx == spm_pkg::IDX_ENABLE) & avs_byteenable[0];
  endsequence

  a_enable_write_takes: assert property (s_enable_write |=>
      gio_enable[7:0] == $past(avs_writedata[7:0]))
    else $error("enable write not applied");
  a_strap_frozen: assert property ((strap_state == ST_LOCKED) |=>
      (strap_state == ST_LOCKED) && $stable(pci_sel))
    else $error("strap selection changed after lock");
  a_single_owner: assert property (host_port_grant != pci_grant)
    else $error("shared pins owned by two peripherals");
  a_quarter_period: assert property ($rose(quarter_clk) |-> ##4 $rose(quarter_clk))
    else $error("quarter-rate clock period wrong");
  a_sixth_period: assert property ($rose(sixth_clk) |-> ##6 $rose(sixth_clk))
    else $error("sixth-rate clock period wrong");
  a_clock_pin_primary: assert property (!gio_enable[1] && !gio_enable[2] |->
      !gio_pin.oe_b[1] && !gio_pin.oe_b[2] && gio_pin.out[1] == quarter_clk)
    else $error("clock pin not driving clock");
  a_gio_direction: assert property (gio_enable[1] && !pci_sel |->
      gio_pin.oe_b[1] == !gio_direction[1] && gio_pin.oe_b[10] == !(gio_enable[10] &&
      gio_direction[10]))
    else $error("general io direction wrong");
  a_upper_pci_owns: assert property (pci_sel |->
      gio_pin.oe_b[15:9] == pci_upper_drive.oe_b[15:9])
    else $error("upper lines not given to PCI");
  a_host_default: assert property (!pci_sel |-> shared_pin == host_drive)
    else $error("shared pins not on host port");
  a_pci_only_hiz: assert property (!pci_sel |-> &pci_only_pin.oe_b)
    else $error("PCI-only pin driven while strap low");

endmodule

`default_nettype wire

// ### spm_board_model.sv
`timescale 1ns/1ns
`default_nettype none

module spm_board_model (
  input wire logic strap_sel,                          // board choice of PCI
  output logic pci_enable_strap,                       // strap level
  output spm_pkg::spm_shared_drive_t host_drive,       // host peripheral drive
  output spm_pkg::spm_shared_drive_t pci_drive,        // PCI drive, shared pins
  output spm_pkg::spm_gio_drive_t pci_upper_drive,     // PCI drive, upper lines
  output spm_pkg::spm_pci_only_drive_t pci_only_drive  // PCI-only pin drive
);
  // strap level held valid; bench changes it only while in reset
  assign pci_enable_strap = strap_sel;
  assign host_drive = '{out: 42'h15555555555, oe_b: 42'h0000000FFFF};
  assign pci_drive = '{out: 42'h2AAAAAAAAAA, oe_b: 42'h3FFFFFF0000};
  assign pci_upper_drive = '{out: 16'hFE00, oe_b: 16'h0000};
  assign pci_only_drive = '{out: 5'h15, oe_b: 5'h00};
endmodule

`default_nettype wire

// ### tb_spm_pin_mux.sv
`timescale 1ns/1ns
`default_nettype none

module tb_spm_pin_mux;
  logic clk, rst_b, avs_read, avs_write, avs_waitrequest, strap_sel, pci_enable_strap;
  logic host_port_grant, pci_grant;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [15:0] gio_ext, gio_pin_in;
  logic [41:0] shared_pin_in, host_port_in, pci_in;
  spm_pkg::spm_gio_drive_t gio_pin, pci_upper_drive;
  spm_pkg::spm_shared_drive_t host_drive, pci_drive, shared_pin;
  spm_pkg::spm_pci_only_drive_t pci_only_drive, pci_only_pin;
  int err_total = 0;
  int tests_run = 0;

  // ----------------------------------------
  // pin wires, clock, parts
  // ----------------------------------------
  assign gio_pin_in = (gio_pin.out & ~gio_pin.oe_b) | (gio_ext & gio_pin.oe_b);
  assign shared_pin_in = (shared_pin.out & ~shared_pin.oe_b) | (42'h1234 & shared_pin.oe_b);
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  spm_board_model spm_board_model_i (.strap_sel(strap_sel),
    .pci_enable_strap(pci_enable_strap), .host_drive(host_drive), .pci_drive(pci_drive),
    .pci_upper_drive(pci_upper_drive), .pci_only_drive(pci_only_drive));
  spm_pin_mux spm_pin_mux_i (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pci_enable_strap(pci_enable_strap),
    .gio_pin_in(gio_pin_in), .gio_pin(gio_pin), .pci_upper_drive(pci_upper_drive),
    .host_drive(host_drive), .pci_drive(pci_drive), .shared_pin_in(shared_pin_in),
    .shared_pin(shared_pin), .host_port_in(host_port_in), .pci_in(pci_in),
    .pci_only_drive(pci_only_drive), .pci_only_pin(pci_only_pin),
    .host_port_grant(host_port_grant), .pci_grant(pci_grant));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [83:0] exp, input logic [83:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    logic w;
    int n;
    n = 0;
    w = 1'b1;
    q = 32'h0000_0000;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    // request held; answer and read data taken at the edge waitrequest is low
    while (w !== 1'b0 && n < 50) begin
      @(posedge clk);
      w = avs_waitrequest;
      q = avs_readdata;
      n++;
    end
    if (w !== 1'b0) begin
      err_total++;
      $display("[FAIL] t=%0t bus stuck exp=%h got=%h", $time, 1'b0, w);
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(exp, q);
  endtask

  // count rises and high cycles of a line over 24 cycles
  task automatic clk_meas(input int idx, input int rises);
    logic p;
    int r, h;
    r = 0;
    h = 0;
    @(negedge clk);
    p = gio_pin.out[idx];
    repeat (24) begin
      @(negedge clk);
      if (gio_pin.out[idx] === 1'b1) h++;
      if (gio_pin.out[idx] === 1'b1 && p === 1'b0) r++;
      p = gio_pin.out[idx];
    end
    chk(rises, r);
    chk(12, h);
    chk(0, gio_pin.oe_b[idx]);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #100000;
    err_total++;
    $display("[FAIL] t=%0t watchdog exp=%h got=%h", $time, 1'b0, 1'b1);
    end_sim;
  end

  initial begin
    rst_b = 0;
    avs_read = 0;
    avs_write = 0;
    avs_address = 8'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h3;
    gio_ext = 16'h0004;
    strap_sel = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    chk(1, host_port_grant);
    chk(0, pci_grant);
    chk(host_drive, shared_pin);
    chk(shared_pin_in, host_port_in);
    chk(10'h01F, pci_only_pin);
    rd(spm_pkg::OFS_ENABLE, 32'h0);
    rd(spm_pkg::OFS_DIRECTION, 32'h0);
    rd(spm_pkg::OFS_STATUS, 32'h2);
    rd(8'hFC, 32'h0);
    $display("test done: defaults");
    clk_meas(1, 6);
    clk_meas(2, 4);
    $display("test done: clock outputs");
    wr(spm_pkg::OFS_DIRECTION, 16'h0202);
    wr(spm_pkg::OFS_OUT_VALUE, 16'h0202);
    wr(spm_pkg::OFS_ENABLE, 16'h0206);
    @(negedge clk);
    chk(3'b101, {gio_pin.out[1], gio_pin.oe_b[1], gio_pin.oe_b[2]});
    chk(2'b10, {gio_pin.out[9], gio_pin.oe_b[9]});
    repeat (6) @(posedge clk);
    rd(spm_pkg::OFS_IN_VALUE, 32'h0206);
    wr(spm_pkg::OFS_ENABLE, 16'h0000);
    clk_meas(1, 6);
    wr(spm_pkg::OFS_STATUS, 16'h0000);
    rd(spm_pkg::OFS_STATUS, 32'h2);
    $display("test done: software switch");
    @(posedge clk);
    rst_b <= 1'b0;
    strap_sel <= 1'b1;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    chk(2'b01, {host_port_grant, pci_grant});
    chk(pci_drive, shared_pin);
    chk(shared_pin_in, pci_in);
    chk(0, host_port_in);
    chk(pci_only_drive, pci_only_pin);
    rd(spm_pkg::OFS_STATUS, 32'h3);
    wr(spm_pkg::OFS_DIRECTION, 16'h0200);
    wr(spm_pkg::OFS_ENABLE, 16'h0200);
    @(negedge clk);
    chk(2'b10, {gio_pin.out[9], gio_pin.oe_b[9]});
    $display("test done: PCI strap");
    end_sim;
  end
endmodule

`default_nettype wire
